// ---- common/config_source_pkg.sv ----
// shared constants and types for the serial configuration bitstream source
package config_source_pkg;
    // core clock and derived link clock timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int CFG_CLK_HALF_NS = 50;
    localparam int CFG_CLK_HALF_CYC = (CFG_CLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // enable/reset low pulse that guarantees a counter reset
    localparam int RESET_PULSE_NS = 100;
    localparam int RESET_PULSE_LV_NS = 150;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_LV_CYC = (RESET_PULSE_LV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // storage shape and prefetch depth
    localparam int WORD_WIDTH_DEFAULT = 8;
    localparam int MEM_WORDS_DEFAULT = 1024;
    localparam int FIFO_DEPTH_DEFAULT = 4;
    // level driven on the data pin after the stream by the reprogrammable variant
    localparam logic DONE_DATA_LEVEL = 1'b1;
    localparam logic [7:0] LOW_COUNT_MAX = 8'hff;
    // link side sequencer
    typedef enum logic [3:0] {
        LINK_PRIME = 4'b0001,
        LINK_SEND = 4'b0010,
        LINK_LAST = 4'b0100,
        LINK_DONE = 4'b1000
    } link_state_type;
endpackage

// ---- common/word_stream_if.sv ----
// valid/ready word stream between the bit shifter and its prefetch fifo
`timescale 1ns/1ps
interface word_stream_if #(parameter int WIDTH = 8);
    logic pushValid;
    logic pushReady;
    logic [WIDTH-1:0] pushData;
    logic popValid;
    logic popReady;
    logic [WIDTH-1:0] popData;
    modport fifo (input pushValid, input pushData, input popReady, output pushReady, output popValid, output popData);
    modport user (output pushValid, output pushData, output popReady, input pushReady, input popValid, input popData);
endinterface

// ---- hw/stream_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic enable,
    word_stream_if.fifo port
);
    // depth must be a power of two so the pointers wrap cleanly
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] slots [DEPTH];
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    wire [AW:0] fill = wrPtr - rdPtr;
    wire full = (fill == FULL_COUNT);
    wire empty = (fill == '0);
    wire doPush = enable & port.pushValid & ~full;
    wire doPop = enable & port.popReady & ~empty;

    // flags straight from the pointers, so full and empty never lie
    assign port.pushReady = ~full;
    assign port.popValid = ~empty;
    assign port.popData = slots[rdPtr[AW-1:0]];

    // pointer update
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (doPush) wrPtr <= wrPtr + 1'b1;
            if (doPop) rdPtr <= rdPtr + 1'b1;
        end
    end

    // storage needs no reset, the pointers guard it
    always_ff @(posedge clk) begin
        if (doPush) slots[wrPtr[AW-1:0]] <= port.pushData;
    end
endmodule

// ---- hw/config_bitstream_source.sv ----
// serial configuration bitstream source: storage, link shifter, clock master and pin control
// Behaviour
// RULE1 - data pin floats before configuration and whenever chip select is high
// RULE2 - after the stream the reprogrammable variant drives data high, others float it
// RULE3 - the fpga samples each data bit on the rising config clock edge
// RULE4 - config clock is driven by a master device and received by a slave
// RULE5 - each rising config clock edge advances the counter and presents the next bit
// RULE6 - counter moves only with enable high, chip select low, data not exhausted
// RULE7 - config clock is held low after configuration and while enable is low
// RULE8 - data output enabled only with enable high and chip select low
// RULE9 - edge after the last bit pulls cascade low and floats data
// RULE10 - cascade output returns high when chip select goes high
// RULE11 - an enable low pulse of at least 100 ns resets the counter
// RULE12 - enable high allows counting; enable low stops the oscillator, clock low
// RULE13 - at reset, chip select low makes a master, high makes a slave
// RULE14 - cascade goes low when the counter reaches its end, feeding the next device
// RULE15 - counter indexes every stored bit and clears to zero on reset
`timescale 1ns/1ps
module config_bitstream_source #(
    parameter int WORD_WIDTH = config_source_pkg::WORD_WIDTH_DEFAULT,
    parameter int MEM_WORDS = config_source_pkg::MEM_WORDS_DEFAULT,
    parameter int FIFO_DEPTH = config_source_pkg::FIFO_DEPTH_DEFAULT,
    parameter bit REPROGRAMMABLE = 1'b1,
    parameter int CLK_HALF_CYC = config_source_pkg::CFG_CLK_HALF_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clkEnable,
    input wire logic configClock,
    output logic configClockOut,
    output logic configClockOeN,
    input wire logic enableResetIn,
    output logic enableResetOut,
    output logic enableResetOeN,
    input wire logic chipSelectN,
    output logic cascadeSelectN,
    output logic serialOut,
    output logic serialOeN,
    input wire logic progWrite,
    input wire logic [$clog2(MEM_WORDS)-1:0] progAddr,
    input wire logic [WORD_WIDTH-1:0] progData
);
    import config_source_pkg::*;

    localparam int TOTAL_BITS = MEM_WORDS * WORD_WIDTH;
    localparam int CNT_W = $clog2(TOTAL_BITS + 1);
    localparam int AW = $clog2(MEM_WORDS);
    localparam int BW = $clog2(WORD_WIDTH);
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(TOTAL_BITS - 1);
    localparam logic [AW-1:0] LAST_WORD = AW'(MEM_WORDS - 1);
    localparam logic [BW-1:0] WORD_END = BW'(WORD_WIDTH - 1);
    localparam logic [7:0] HALF_LAST = 8'(CLK_HALF_CYC - 1);
    localparam logic [7:0] PULSE_CYC = 8'(RESET_PULSE_CYC);

    // ---------------- core clock domain ----------------
    logic enMeta;
    logic enSync;
    logic csMeta;
    logic csSync;
    logic doneMeta;
    logic doneSync;
    logic doneLink;
    logic isMaster;
    logic clearN;
    logic [7:0] divCount;
    logic cfgClkReg;
    logic [WORD_WIDTH-1:0] storage [MEM_WORDS];

    // enable/reset and chip select pins pass two flops before any logic reads them; the programming port is used unsynchronised
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enMeta <= 1'b0;
            enSync <= 1'b0;
            csMeta <= 1'b1;
            csSync <= 1'b1;
        end else if (clkEnable) begin
            enMeta <= enableResetIn;
            enSync <= enMeta;
            csMeta <= chipSelectN;
            csSync <= csMeta;
        end
    end

    // end-of-stream flag coming back from the link domain
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            doneMeta <= 1'b0;
            doneSync <= 1'b0;
        end else if (clkEnable) begin
            doneMeta <= doneLink;
            doneSync <= doneMeta;
        end
    end

    // role is sampled while enable/reset is held low, the last value wins at release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            isMaster <= 1'b0;
        end else if (clkEnable && !enSync) begin
            isMaster <= ~csSync; // RULE13
        end
    end

    // link reset request: registered so the async reset has no glitches
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clearN <= 1'b0;
        end else if (clkEnable) begin
            clearN <= enSync; // RULE11 RULE12
        end
    end

    // oscillator runs only for a master with enable high and the fpga still loading
    wire clockRun = isMaster & enSync & ~csSync; // RULE7 RULE12
    wire halfDone = (divCount == HALF_LAST);

    // divider that makes the config clock; parked low whenever it must not run
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divCount <= '0;
            cfgClkReg <= 1'b0;
        end else if (clkEnable) begin
            if (!clockRun) begin
                divCount <= '0;
                cfgClkReg <= 1'b0; // RULE7
            end else if (halfDone) begin
                divCount <= '0;
                cfgClkReg <= ~cfgClkReg;
            end else begin
                divCount <= divCount + 8'h01;
            end
        end
    end

    // loading is allowed only while the device is held in reset by enable low
    wire progAccept = clkEnable & progWrite & ~enSync;

    // storage write port; the link domain reads it only while this port is closed
    always_ff @(posedge clk) begin
        if (progAccept) storage[progAddr] <= progData;
    end

    // pin drivers: enables are active low
    assign configClockOut = cfgClkReg;
    assign configClockOeN = ~isMaster; // RULE4
    assign enableResetOut = 1'b0;
    assign enableResetOeN = 1'b1;

    // data drives only with enable high and chip select low; after the stream only in the reprogrammable variant
    wire dataLive = enSync & ~csSync; // RULE1 RULE8
    assign serialOeN = ~(dataLive & (~doneSync | REPROGRAMMABLE)); // RULE2 RULE9
    assign cascadeSelectN = ~(doneSync & ~csSync); // RULE9 RULE10 RULE14

    // async reset of the link logic: asserted at once, released by the link clock
    wire linkArstN = resetn & clearN;

    // ---------------- link clock domain ----------------
    logic rstMeta;
    logic linkRstN;
    logic csL1;
    logic csL2;
    logic ceL1;
    logic ceL2;
    logic [AW-1:0] fetchAddr;
    logic fetchDone;
    link_state_type state;
    link_state_type next_state;
    logic [WORD_WIDTH-1:0] curWord;
    logic [BW-1:0] bitIdx;
    logic [CNT_W-1:0] bitCount;
    logic dataBit;

    // reset release synchroniser; the stopped clock cannot release it early
    always_ff @(posedge configClock or negedge linkArstN) begin
        if (!linkArstN) begin
            rstMeta <= 1'b0;
            linkRstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            linkRstN <= rstMeta;
        end
    end

    // chip select and clock enable brought onto the link clock
    always_ff @(posedge configClock or negedge linkRstN) begin
        if (!linkRstN) begin
            csL1 <= 1'b1;
            csL2 <= 1'b1;
            ceL1 <= 1'b0;
            ceL2 <= 1'b0;
        end else begin
            csL1 <= chipSelectN;
            csL2 <= csL1;
            ceL1 <= clkEnable;
            ceL2 <= ceL1;
        end
    end

    word_stream_if #(.WIDTH(WORD_WIDTH)) prefetch ();

    stream_fifo #(.WIDTH(WORD_WIDTH), .DEPTH(FIFO_DEPTH)) prefetchFifo (
        .clk(configClock),
        .resetn(linkRstN),
        .enable(ceL2),
        .port(prefetch)
    );

    // counting condition; enable high is implied by the link being out of reset
    wire linkActive = ceL2 & ~csL2; // RULE6
    wire wordEnd = (bitIdx == WORD_END);
    wire streamEnd = (bitCount == LAST_BIT);
    wire fetchTake = ceL2 & ~fetchDone & prefetch.pushReady;

    // prefetch keeps the fifo topped up so the shifter never starves mid-word
    assign prefetch.pushValid = ~fetchDone;
    assign prefetch.pushData = storage[fetchAddr];
    assign prefetch.popReady = ceL2 & ((state == LINK_PRIME)
        | ((state == LINK_SEND) & linkActive & wordEnd & ~streamEnd));

    // word fetch address
    always_ff @(posedge configClock or negedge linkRstN) begin
        if (!linkRstN) begin
            fetchAddr <= '0;
            fetchDone <= 1'b0;
        end else if (fetchTake) begin
            fetchAddr <= fetchAddr + 1'b1;
            fetchDone <= (fetchAddr == LAST_WORD);
        end
    end

    // sequencer: prime the first word, send bits, one more edge, then done
    always_comb begin
        next_state = state;
        unique case (state)
            LINK_PRIME: begin
                if (prefetch.popValid) next_state = LINK_SEND;
            end
            LINK_SEND: begin
                if (linkActive && streamEnd) begin
                    next_state = LINK_LAST;
                end else if (linkActive && wordEnd && !prefetch.popValid) begin
                    next_state = LINK_PRIME;
                end
            end
            LINK_LAST: begin
                if (linkActive) next_state = LINK_DONE; // RULE9
            end
            LINK_DONE: begin
                next_state = LINK_DONE;
            end
            default: begin
                next_state = LINK_PRIME;
            end
        endcase
    end

    // state register
    always_ff @(posedge configClock or negedge linkRstN) begin
        if (!linkRstN) begin
            state <= LINK_PRIME;
        end else if (ceL2) begin
            state <= next_state;
        end
    end

    // shifter: bit leaves on the rising edge so the fpga samples it on the next one
    always_ff @(posedge configClock or negedge linkRstN) begin
        if (!linkRstN) begin
            curWord <= '0;
            bitIdx <= '0;
            bitCount <= '0; // RULE15
            dataBit <= 1'b0;
        end else if (ceL2) begin
            if (prefetch.popReady && prefetch.popValid) begin
                curWord <= prefetch.popData;
            end
            if (state == LINK_SEND && linkActive) begin
                dataBit <= curWord[bitIdx]; // RULE3 RULE5
                bitIdx <= wordEnd ? '0 : bitIdx + 1'b1;
                bitCount <= bitCount + 1'b1; // RULE5 RULE6
            end else if (state == LINK_LAST && linkActive) begin
                dataBit <= DONE_DATA_LEVEL; // RULE2
            end
        end
    end

    // stream exhausted flag, crossed to the core domain by two flops
    always_ff @(posedge configClock or negedge linkRstN) begin
        if (!linkRstN) begin
            doneLink <= 1'b0;
        end else if (ceL2) begin
            doneLink <= (next_state == LINK_DONE); // RULE14
        end
    end

    assign serialOut = dataBit;

    // ---------------- checks ----------------
    logic [7:0] lowCount;

    // counts cycles of enable held low, saturating
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lowCount <= '0;
        end else if (clkEnable) begin
            if (enSync) lowCount <= '0;
            else if (lowCount != LOW_COUNT_MAX) lowCount <= lowCount + 8'h01;
        end
    end

    sequence sendEdge;
        ceL2 && state == LINK_SEND && linkActive;
    endsequence

    sequence lastEdge;
        ceL2 && state == LINK_LAST && linkActive;
    endsequence

    a_data_off_cs: // RULE1
    assert property (@(posedge clk) disable iff (!resetn) csSync |-> serialOeN)
        else $error("data pin driven while chip select high");

    a_data_off_disable: // RULE8
    assert property (@(posedge clk) disable iff (!resetn) !enSync |-> serialOeN)
        else $error("data pin still driven after enable went low");

    a_clock_held_low: // RULE7
    assert property (@(posedge clk) disable iff (!resetn)
        (clkEnable && (csSync || !enSync)) |=> !configClockOut)
        else $error("config clock not low after completion or disable");

    a_clock_pin_role: // RULE4
    assert property (@(posedge clk) disable iff (!resetn)
        $rose(configClockOut) |-> !configClockOeN)
        else $error("config clock toggled while pin not driven");

    a_master_strap: // RULE13
    assert property (@(posedge clk) disable iff (!resetn)
        (clkEnable && !enSync) |=> (isMaster == !$past(csSync)))
        else $error("master role not taken from chip select at reset");

    a_cascade_release: // RULE10
    assert property (@(posedge clk) disable iff (!resetn) $rose(csSync) |-> cascadeSelectN)
        else $error("cascade not released with chip select high");

    a_cascade_low_done: // RULE14
    assert property (@(posedge clk) disable iff (!resetn)
        ($rose(doneSync) && !csSync) |-> !cascadeSelectN)
        else $error("cascade not low at end of data");

    a_counter_reset: // RULE11
    assert property (@(posedge clk) disable iff (!resetn)
        (clkEnable && lowCount == PULSE_CYC) |-> !linkArstN)
        else $error("long enable low pulse did not reset the counter");

    a_count_advance: // RULE5
    assert property (@(posedge configClock) disable iff (!linkRstN)
        sendEdge |=> (bitCount == $past(bitCount) + 1'b1))
        else $error("counter did not advance on an active edge");

    a_count_hold: // RULE6
    assert property (@(posedge configClock) disable iff (!linkRstN)
        (!linkActive || state != LINK_SEND) |=> $stable(bitCount))
        else $error("counter moved while not allowed");

    a_end_of_data: // RULE9
    assert property (@(posedge configClock) disable iff (!linkRstN)
        lastEdge |=> doneLink && dataBit == DONE_DATA_LEVEL)
        else $error("edge after last bit did not end the stream");

    a_done_level: // RULE2
    assert property (@(posedge clk) disable iff (!resetn)
        (doneSync && dataLive) |-> (serialOeN == !REPROGRAMMABLE) && serialOut == DONE_DATA_LEVEL)
        else $error("wrong data pin state after configuration");
endmodule

// ---- verif/fpga_config_port.sv ----
// behavioural fpga serial configuration port that takes the bitstream
`timescale 1ns/1ps
module fpga_config_port #(
    parameter logic [31:0] IMAGE = 32'h0000_0000,
    parameter int DONE_HOLD = 0
) (
    input wire logic configClock,
    input wire logic serialOut,
    input wire logic serialOeN,
    input wire logic clear,
    output logic fpgaConfigComplete,
    output logic [31:0] history,
    output logic [3:0] tail
);
    logic lastBit;
    logic fpgaSerialIn;
    logic matched;
    int tailCount;
    // a released data line shows the inverse of its last level, so a stale copy never passes
    assign fpgaSerialIn = serialOeN ? ~lastBit : serialOut;
    // bits are taken on the rising config clock only while the source drives the line
    always @(posedge configClock or posedge clear) begin
        if (clear) begin
            lastBit <= 1'b0;
            history <= 32'h0000_0000;
            tail <= 4'h0;
            matched <= 1'b0;
            tailCount <= 0;
            fpgaConfigComplete <= 1'b0;
        end else if (!serialOeN) begin
            lastBit <= fpgaSerialIn;
            if (!matched) begin
                history <= {fpgaSerialIn, history[31:1]};
                matched <= ({fpgaSerialIn, history[31:1]} == IMAGE);
            end else if (tailCount < 4) begin
                tail <= {fpgaSerialIn, tail[3:1]};
                tailCount <= tailCount + 1;
            end else if (tailCount < 4 + DONE_HOLD) begin
                tailCount <= tailCount + 1; // slow answer: extra clocks before done
            end else begin
                fpgaConfigComplete <= 1'b1;
            end
        end
    end
endmodule

// ---- verif/serial_config_bitstream_source_tb.sv ----
// self-checking bench for the serial configuration bitstream source
`timescale 1ns/1ps
module serial_config_bitstream_source_tb;
    import config_source_pkg::*;
    localparam logic [31:0] IMAGE = 32'h3c96_5aa5;
    typedef struct packed {logic en; logic csN; logic oeN; logic clkOeN;} row_type;
    // the last row releases enable as chip select rises: the role seen during reset (master) holds
    localparam row_type ROWS [3] = '{'{1'b0, 1'b1, 1'b1, 1'b1}, '{1'b0, 1'b0, 1'b1, 1'b0}, '{1'b1, 1'b1, 1'b1, 1'b0}};
    logic clk, resetn, enIn, csN, slaveRun, slaveClk, modelClear, sawCasc;
    logic progWrite;
    logic clkEn, enOut, enOeN;
    logic [1:0] progAddr;
    logic [7:0] progData;
    logic configClockOut, configClockOeN, cascadeSelectN, serialOut, serialOeN, fpgaConfigComplete;
    logic cfgPin, chipSelectN;
    logic [31:0] history;
    logic [3:0] tail;
    int n_errors = 0;
    int checks = 0;
    // the pin wire: the device drives it as master, otherwise the bench clock stands in
    assign cfgPin = configClockOeN ? slaveClk : configClockOut;
    assign chipSelectN = csN | fpgaConfigComplete;
    config_bitstream_source #(.MEM_WORDS(4), .CLK_HALF_CYC(2)) dut (.clk(clk), .resetn(resetn), .clkEnable(clkEn),
        .configClock(cfgPin), .configClockOut(configClockOut), .configClockOeN(configClockOeN),
        .enableResetIn(enIn), .enableResetOut(enOut), .enableResetOeN(enOeN), .chipSelectN(chipSelectN),
        .cascadeSelectN(cascadeSelectN), .serialOut(serialOut), .serialOeN(serialOeN), .progWrite(progWrite),
        .progAddr(progAddr), .progData(progData));
    fpga_config_port #(.IMAGE(IMAGE), .DONE_HOLD(3)) fpga (.configClock(cfgPin), .serialOut(serialOut),
        .serialOeN(serialOeN), .clear(modelClear), .fpgaConfigComplete(fpgaConfigComplete), .history(history),
        .tail(tail));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // slave link clock, 12 ns, off phase, still outside frames
    initial begin
        slaveClk = 1'b0;
        #1.3;
        forever begin
            #6;
            slaveClk = slaveRun ? ~slaveClk : 1'b0;
        end
    end
    // remembers a cascade low pulse, which may be short once the fpga finishes
    always @(posedge clk) begin
        sawCasc <= modelClear ? 1'b0 : (sawCasc | (cascadeSelectN === 1'b0));
    end
    task automatic check(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // pins change on a clock edge and are held a full reset pulse before looking
    task automatic set_pins(input logic en, input logic cs);
        @(posedge clk);
        enIn <= en;
        csN <= cs;
        repeat (RESET_PULSE_CYC) @(posedge clk);
        #1;
    endtask
    task automatic clear_model();
        @(posedge clk);
        modelClear <= 1'b1;
        @(posedge clk);
        modelClear <= 1'b0;
    endtask
    task automatic wait_done();
        for (int i = 0; i < 2000 && fpgaConfigComplete !== 1'b1; i++) @(posedge clk);
        #1;
        check(fpgaConfigComplete, 1'b1);
        check(history === IMAGE, 1'b1);
    endtask
    task automatic check_quiet(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            check(configClockOut, 1'b0);
            check(serialOeN, 1'b1);
        end
    endtask
    initial begin
        resetn = 1'b0;
        enIn = 1'b0;
        csN = 1'b1;
        slaveRun = 1'b0;
        modelClear = 1'b1;
        progWrite = 1'b0;
        clkEn = 1'b1;
        progAddr = 2'h0;
        progData = 8'h00;
        repeat (10) @(posedge clk);
        #1;
        check(serialOeN, 1'b1);
        check(cascadeSelectN, 1'b1);
        check(configClockOut, 1'b0);
        check(enOeN & ~enOut, 1'b1);
        @(posedge clk);
        resetn <= 1'b1;
        modelClear <= 1'b0;
        // store loaded back to back while enable is low
        for (int w = 0; w < 4; w++) begin
            @(posedge clk);
            progWrite <= 1'b1;
            progAddr <= 2'(w);
            progData <= IMAGE[8*w+:8];
        end
        @(posedge clk);
        progWrite <= 1'b0;
        foreach (ROWS[i]) begin
            set_pins(ROWS[i].en, ROWS[i].csN);
            check(serialOeN, ROWS[i].oeN);
            check(configClockOeN, ROWS[i].clkOeN);
        end
        // a write with enable high must leave the store alone
        @(posedge clk);
        progWrite <= 1'b1;
        progAddr <= 2'h0;
        progData <= ~IMAGE[7:0];
        @(posedge clk);
        progWrite <= 1'b0;
        // a frozen core must not take a new role although the pins ask for a slave
        clkEn <= 1'b0;
        set_pins(1'b0, 1'b1);
        check(configClockOeN, 1'b0);
        @(posedge clk);
        clkEn <= 1'b1;
        // master run of the full image
        set_pins(1'b0, 1'b0);
        clear_model();
        set_pins(1'b1, 1'b0);
        check(configClockOeN, 1'b0);
        wait_done();
        check(tail === 4'hf, 1'b1);
        check(sawCasc, 1'b1);
        repeat (10) @(posedge clk);
        #1;
        check(cascadeSelectN, 1'b1);
        check_quiet(20);
        // enable dropped in mid-stream, then a full restart from bit zero
        set_pins(1'b0, 1'b0);
        clear_model();
        @(posedge clk);
        enIn <= 1'b1;
        repeat (60) @(posedge clk);
        enIn <= 1'b0;
        repeat (4) @(posedge clk);
        check_quiet(RESET_PULSE_CYC - 4);
        clear_model();
        @(posedge clk);
        enIn <= 1'b1;
        wait_done();
        // slave run on the bench clock
        set_pins(1'b0, 1'b1);
        set_pins(1'b1, 1'b1);
        check(configClockOeN, 1'b1);
        clear_model();
        @(posedge clk);
        csN <= 1'b0;
        slaveRun <= 1'b1;
        wait_done();
        slaveRun <= 1'b0;
        summarize();
    end
    // watchdog well beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        summarize();
    end
endmodule
